// ---- design/hup_pkg.sv ----
// Functional notes
// - UART starts at fixed 115200 bps, no autobaud
// - Host command raises rate, at most 3 Mbps
// - Bytes LSB first, no parity, one stop bit
// - Host interrupt active high, edge or level
// - Multi-byte fields travel little-endian
// - Five-wire: four UART lines plus interrupt
// - Host should prefer the five-wire arrangement
// - Four-wire host stays awake or start-edge wakes
// - Three-wire host stays awake or start-edge wakes
// - Three-wire host absorbs full-rate data unthrottled
// - Device raises interrupt when host service pending
// - Host SPI clock at most 20 MHz, device slave
// - Device answers only while select low
// - Device drives its data on master-in line
// - Hibernate request low puts device in hibernate
// - Select leads and trails clock by 10 ns
package hup_pkg;
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned INIT_BAUD     = 115_200;
   localparam int unsigned MAX_BAUD      = 3_000_000;
   localparam int unsigned SPI_MAX_HZ    = 20_000_000;
   localparam int unsigned SEL_GUARD_NS  = 10;
   localparam int unsigned DIV_W         = 16;
   // Cycles per bit; the ceiling rounds the divisor up so the rate stays below the limit
   localparam logic [15:0] INIT_DIV      = 16'(CLK_HZ / INIT_BAUD);
   localparam logic [15:0] MIN_DIV       = 16'((CLK_HZ + MAX_BAUD - 1) / MAX_BAUD);
   localparam logic [7:0]  SPI_HALF_CYC  = 8'((CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ));
   localparam logic [7:0]  SEL_GUARD_CYC = 8'((SEL_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0]  CMD_BAUD      = 8'hB7;
   localparam logic [3:0]  UART_LAST_BIT = 4'h9;
   localparam logic [2:0]  SPI_LAST_BIT  = 3'h7;
endpackage

// ---- design/hup_link_if.sv ----
interface hup_link_if;
   logic dev_to_host;
   logic host_to_dev;
   logic host_rts_n;
   logic dev_rts_n;
   logic host_irq_out;
   logic spi_sclk;
   logic host_select_n;
   logic spi_mosi;
   logic spi_miso;
   logic spi_miso_oe;
   logic hibernate_req_n;

   modport dev (
      output dev_to_host,
      input  host_to_dev,
      input  host_rts_n,
      output dev_rts_n,
      output host_irq_out,
      input  spi_sclk,
      input  host_select_n,
      input  spi_mosi,
      output spi_miso,
      output spi_miso_oe,
      input  hibernate_req_n
   );

   modport host (
      input  dev_to_host,
      output host_to_dev,
      output host_rts_n,
      input  dev_rts_n,
      input  host_irq_out,
      output spi_sclk,
      output host_select_n,
      output spi_mosi,
      input  spi_miso,
      input  spi_miso_oe,
      output hibernate_req_n
   );
endinterface

// ---- design/hup_dev_end.sv ----
module hup_uart #(
   parameter int DIV_W = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [DIV_W-1:0] div,
   input  wire logic [7:0]       tx_data,
   input  wire logic             tx_valid,
   input  wire logic             tx_allow,
   output logic                  tx_ready,
   output logic                  tx_idle,
   output logic                  tx_line,
   input  wire logic             rx_line,
   output logic [7:0]            rx_data,
   output logic                  rx_valid
);
   logic             tx_busy, next_tx_busy;
   logic [DIV_W-1:0] tx_cnt, next_tx_cnt;
   logic [3:0]       tx_bit, next_tx_bit;
   logic [9:0]       tx_shift, next_tx_shift;
   logic             rx_busy, next_rx_busy;
   logic [DIV_W-1:0] rx_cnt, next_rx_cnt;
   logic [3:0]       rx_bit, next_rx_bit;
   logic [7:0]       rx_shift, next_rx_shift;
   logic [7:0]       next_rx_data;
   logic             next_rx_valid;

   assign tx_ready = !tx_busy && tx_allow;
   assign tx_idle  = !tx_busy;
   assign tx_line  = tx_shift[0];

   always_comb begin
      next_tx_busy  = tx_busy;
      next_tx_cnt   = tx_cnt;
      next_tx_bit   = tx_bit;
      next_tx_shift = tx_shift;
      if (!tx_busy) begin
         if (tx_valid && tx_allow) begin
            // Start bit, data LSB first, one stop bit, no parity
            next_tx_shift = {1'b1, tx_data, 1'b0};
            next_tx_busy  = 1'b1;
            next_tx_cnt   = div - 1'b1;
            next_tx_bit   = 4'h0;
         end
      end else if (tx_cnt == '0) begin
         next_tx_shift = {1'b1, tx_shift[9:1]};
         next_tx_cnt   = div - 1'b1;
         next_tx_bit   = tx_bit + 4'h1;
         if (tx_bit == hup_pkg::UART_LAST_BIT) begin
            next_tx_busy = 1'b0;
         end
      end else begin
         next_tx_cnt = tx_cnt - 1'b1;
      end
   end

   always_comb begin
      next_rx_busy  = rx_busy;
      next_rx_cnt   = rx_cnt;
      next_rx_bit   = rx_bit;
      next_rx_shift = rx_shift;
      next_rx_data  = rx_data;
      next_rx_valid = 1'b0;
      if (!rx_busy) begin
         if (!rx_line) begin
            next_rx_busy = 1'b1;
            next_rx_cnt  = div >> 1;
            next_rx_bit  = 4'h0;
         end
      end else if (rx_cnt == '0) begin
         next_rx_cnt = div - 1'b1;
         next_rx_bit = rx_bit + 4'h1;
         if (rx_bit == 4'h0) begin
            // Glitch rather than start bit
            if (rx_line) begin
               next_rx_busy = 1'b0;
            end
         end else if (rx_bit == hup_pkg::UART_LAST_BIT) begin
            next_rx_busy = 1'b0;
            if (rx_line) begin
               next_rx_data  = rx_shift;
               next_rx_valid = 1'b1;
            end
         end else begin
            next_rx_shift = {rx_line, rx_shift[7:1]};
         end
      end else begin
         next_rx_cnt = rx_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_busy  <= 1'b0;
         tx_cnt   <= '0;
         tx_bit   <= 4'h0;
         tx_shift <= 10'h3FF;
         rx_busy  <= 1'b0;
         rx_cnt   <= '0;
         rx_bit   <= 4'h0;
         rx_shift <= 8'h00;
         rx_data  <= 8'h00;
         rx_valid <= 1'b0;
      end else begin
         tx_busy  <= next_tx_busy;
         tx_cnt   <= next_tx_cnt;
         tx_bit   <= next_tx_bit;
         tx_shift <= next_tx_shift;
         rx_busy  <= next_rx_busy;
         rx_cnt   <= next_rx_cnt;
         rx_bit   <= next_rx_bit;
         rx_shift <= next_rx_shift;
         rx_data  <= next_rx_data;
         rx_valid <= next_rx_valid;
      end
   end
endmodule

module hup_dev_end (
   input  wire logic        clk,
   input  wire logic        reset_n,
   hup_link_if.dev          link,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [7:0]       rx_data,
   output logic             rx_valid,
   input  wire logic        rx_hold,
   input  wire logic        flow_en,
   input  wire logic        event_req,
   input  wire logic [7:0]  spi_tx_data,
   output logic [7:0]       spi_rx_data,
   output logic             spi_rx_valid,
   output logic             hibernate,
   output logic [15:0]      baud_div
);
   typedef enum logic [1:0] {HUP_BD_DATA, HUP_BD_LO, HUP_BD_HI} hup_bd_state_t;

   hup_bd_state_t bd_state, next_bd_state;
   logic [15:0]   next_baud_div;
   logic [7:0]    div_lo, next_div_lo;
   logic [7:0]    next_rx_data;
   logic          next_rx_valid;
   logic [7:0]    u_rx_data;
   logic          u_rx_valid;
   logic          u_tx_ready;
   logic          tx_allow;
   logic          next_hibernate;
   logic          next_irq;
   logic          next_rts_n;
   logic          sclk_q, next_sclk_q;
   logic [2:0]    spi_bit, next_spi_bit;
   logic [7:0]    spi_in, next_spi_in;
   logic [7:0]    spi_out, next_spi_out;
   logic [7:0]    next_spi_rx_data;
   logic          next_spi_rx_valid;
   logic          next_miso_oe;
   logic [15:0]   req_div;

   // Host line gates our transmitter only when flow control is on
   assign tx_allow = !hibernate && (!flow_en || !link.host_rts_n);
   assign tx_ready = u_tx_ready;

   hup_uart #(.DIV_W(hup_pkg::DIV_W)) u_uart (
      .clk      (clk),
      .reset_n  (reset_n),
      .div      (baud_div),
      .tx_data  (tx_data),
      .tx_valid (tx_valid),
      .tx_allow (tx_allow),
      .tx_ready (u_tx_ready),
      .tx_idle  (),
      .tx_line  (link.dev_to_host),
      .rx_line  (link.host_to_dev),
      .rx_data  (u_rx_data),
      .rx_valid (u_rx_valid)
   );

   assign link.spi_miso = spi_out[7];
   assign req_div       = {u_rx_data, div_lo};

   // Baud command: opcode, then divisor low byte, then high byte
   always_comb begin
      next_bd_state = bd_state;
      next_baud_div = baud_div;
      next_div_lo   = div_lo;
      next_rx_data  = rx_data;
      next_rx_valid = 1'b0;
      if (u_rx_valid && !hibernate) begin
         case (bd_state)
            HUP_BD_DATA: begin
               if (u_rx_data == hup_pkg::CMD_BAUD) begin
                  next_bd_state = HUP_BD_LO;
               end else begin
                  next_rx_data  = u_rx_data;
                  next_rx_valid = 1'b1;
               end
            end
            HUP_BD_LO: begin
               next_div_lo   = u_rx_data;
               next_bd_state = HUP_BD_HI;
            end
            HUP_BD_HI: begin
               // Clamp keeps the rate at or under the ceiling
               next_baud_div = (req_div < hup_pkg::MIN_DIV) ? hup_pkg::MIN_DIV : req_div;
               next_bd_state = HUP_BD_DATA;
            end
            default: next_bd_state = HUP_BD_DATA;
         endcase
      end
   end

   always_comb begin
      next_hibernate = !link.hibernate_req_n;
      next_irq       = !hibernate && (event_req || tx_valid);
      next_rts_n     = hibernate || rx_hold;
   end

   // SPI slave, mode 0: sample on rising, shift out on falling
   always_comb begin
      next_sclk_q       = link.spi_sclk;
      next_spi_bit      = spi_bit;
      next_spi_in       = spi_in;
      next_spi_out      = spi_out;
      next_spi_rx_data  = spi_rx_data;
      next_spi_rx_valid = 1'b0;
      next_miso_oe      = !link.host_select_n && !hibernate;
      if (link.host_select_n || hibernate) begin
         next_spi_bit = 3'h0;
         next_spi_out = spi_tx_data;
      end else if (link.spi_sclk && !sclk_q) begin
         next_spi_in  = {spi_in[6:0], link.spi_mosi};
         next_spi_bit = spi_bit + 3'h1;
         if (spi_bit == hup_pkg::SPI_LAST_BIT) begin
            next_spi_rx_data  = {spi_in[6:0], link.spi_mosi};
            next_spi_rx_valid = 1'b1;
         end
      end else if (!link.spi_sclk && sclk_q) begin
         next_spi_out = (spi_bit == 3'h0) ? spi_tx_data : {spi_out[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bd_state          <= HUP_BD_DATA;
         baud_div          <= hup_pkg::INIT_DIV;
         div_lo            <= 8'h00;
         rx_data           <= 8'h00;
         rx_valid          <= 1'b0;
         hibernate         <= 1'b0;
         link.host_irq_out <= 1'b0;
         link.dev_rts_n    <= 1'b1;
         sclk_q            <= 1'b0;
         spi_bit           <= 3'h0;
         spi_in            <= 8'h00;
         spi_out           <= 8'h00;
         spi_rx_data       <= 8'h00;
         spi_rx_valid      <= 1'b0;
         link.spi_miso_oe  <= 1'b0;
      end else begin
         bd_state          <= next_bd_state;
         baud_div          <= next_baud_div;
         div_lo            <= next_div_lo;
         rx_data           <= next_rx_data;
         rx_valid          <= next_rx_valid;
         hibernate         <= next_hibernate;
         link.host_irq_out <= next_irq;
         link.dev_rts_n    <= next_rts_n;
         sclk_q            <= next_sclk_q;
         spi_bit           <= next_spi_bit;
         spi_in            <= next_spi_in;
         spi_out           <= next_spi_out;
         spi_rx_data       <= next_spi_rx_data;
         spi_rx_valid      <= next_spi_rx_valid;
         link.spi_miso_oe  <= next_miso_oe;
      end
   end
endmodule

// ---- design/hup_host_end.sv ----
module hup_host_end (
   input  wire logic        clk,
   input  wire logic        reset_n,
   hup_link_if.host         link,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [7:0]       rx_data,
   output logic             rx_valid,
   input  wire logic        rx_hold,
   input  wire logic        flow_en,
   input  wire logic        baud_req,
   input  wire logic [15:0] baud_div_in,
   output logic             baud_busy,
   output logic [15:0]      baud_div,
   output logic             irq_event,
   output logic             irq_level,
   input  wire logic        spi_start,
   input  wire logic [7:0]  spi_wdata,
   output logic             spi_busy,
   output logic [7:0]       spi_rdata,
   output logic             spi_done,
   input  wire logic        hib_req
);
   typedef enum logic [2:0] {HUP_HB_IDLE, HUP_HB_CMD, HUP_HB_LO, HUP_HB_HI, HUP_HB_WAIT}
      hup_hb_state_t;
   typedef enum logic [1:0] {HUP_SP_IDLE, HUP_SP_SETUP, HUP_SP_RUN, HUP_SP_HOLD} hup_sp_state_t;

   hup_hb_state_t hb_state, next_hb_state;
   hup_sp_state_t sp_state, next_sp_state;
   logic [15:0]   pend_div, next_pend_div;
   logic [15:0]   next_baud_div;
   logic [7:0]    u_tx_data;
   logic          u_tx_valid, u_tx_ready, u_tx_idle, tx_allow;
   logic          irq_q, next_irq_q, next_irq_event;
   logic [7:0]    sp_cnt, next_sp_cnt;
   logic [4:0]    sp_edges, next_sp_edges;
   logic [7:0]    sp_shift, next_sp_shift;
   logic          sclk, next_sclk, sel_n, next_sel_n;
   logic [7:0]    next_spi_rdata;
   logic          next_spi_done;
   logic          next_rts_n, next_hib_n;

   assign tx_allow  = !flow_en || !link.dev_rts_n;
   assign baud_busy = hb_state != HUP_HB_IDLE;
   assign tx_ready  = !baud_busy && u_tx_ready;
   assign spi_busy  = sp_state != HUP_SP_IDLE;
   assign link.spi_sclk      = sclk;
   assign link.host_select_n = sel_n;
   assign link.spi_mosi      = sp_shift[7];

   always_comb begin
      u_tx_data  = tx_data;
      u_tx_valid = tx_valid && !baud_busy;
      case (hb_state)
         HUP_HB_CMD: u_tx_data = hup_pkg::CMD_BAUD;
         HUP_HB_LO:  u_tx_data = pend_div[7:0];
         HUP_HB_HI:  u_tx_data = pend_div[15:8];
         default:    u_tx_data = tx_data;
      endcase
      if (hb_state == HUP_HB_CMD || hb_state == HUP_HB_LO || hb_state == HUP_HB_HI) begin
         u_tx_valid = 1'b1;
      end
   end

   hup_uart #(.DIV_W(hup_pkg::DIV_W)) u_uart (
      .clk      (clk),
      .reset_n  (reset_n),
      .div      (baud_div),
      .tx_data  (u_tx_data),
      .tx_valid (u_tx_valid),
      .tx_allow (tx_allow),
      .tx_ready (u_tx_ready),
      .tx_idle  (u_tx_idle),
      .tx_line  (link.host_to_dev),
      .rx_line  (link.dev_to_host),
      .rx_data  (rx_data),
      .rx_valid (rx_valid)
   );

   // Own rate switches only after the last command byte has left
   always_comb begin
      next_hb_state = hb_state;
      next_pend_div = pend_div;
      next_baud_div = baud_div;
      case (hb_state)
         HUP_HB_IDLE: begin
            if (baud_req && u_tx_idle) begin
               next_pend_div = (baud_div_in < hup_pkg::MIN_DIV) ? hup_pkg::MIN_DIV : baud_div_in;
               next_hb_state = HUP_HB_CMD;
            end
         end
         HUP_HB_CMD:  if (u_tx_ready) next_hb_state = HUP_HB_LO;
         HUP_HB_LO:   if (u_tx_ready) next_hb_state = HUP_HB_HI;
         HUP_HB_HI:   if (u_tx_ready) next_hb_state = HUP_HB_WAIT;
         HUP_HB_WAIT: begin
            if (u_tx_idle) begin
               next_baud_div = pend_div;
               next_hb_state = HUP_HB_IDLE;
            end
         end
         default: next_hb_state = HUP_HB_IDLE;
      endcase
   end

   always_comb begin
      next_irq_q     = link.host_irq_out;
      next_irq_event = link.host_irq_out && !irq_q;
      next_rts_n     = rx_hold;
      next_hib_n     = !hib_req;
   end

   // SPI master: guard cycles around the clock burst
   always_comb begin
      next_sp_state  = sp_state;
      next_sp_cnt    = sp_cnt;
      next_sp_edges  = sp_edges;
      next_sp_shift  = sp_shift;
      next_sclk      = sclk;
      next_sel_n     = sel_n;
      next_spi_rdata = spi_rdata;
      next_spi_done  = 1'b0;
      case (sp_state)
         HUP_SP_IDLE: begin
            if (spi_start) begin
               next_sel_n    = 1'b0;
               next_sp_shift = spi_wdata;
               next_sp_cnt   = hup_pkg::SEL_GUARD_CYC;
               next_sp_state = HUP_SP_SETUP;
            end
         end
         HUP_SP_SETUP: begin
            if (sp_cnt <= 8'h1) begin
               next_sp_cnt   = hup_pkg::SPI_HALF_CYC;
               next_sp_edges = 5'h0;
               next_sp_state = HUP_SP_RUN;
            end else begin
               next_sp_cnt = sp_cnt - 8'h1;
            end
         end
         HUP_SP_RUN: begin
            if (sp_cnt <= 8'h1) begin
               next_sp_cnt   = hup_pkg::SPI_HALF_CYC;
               next_sp_edges = sp_edges + 5'h1;
               if (sp_edges[0] == 1'b0) begin
                  next_sclk = 1'b1;
               end else begin
                  // Shift on the falling edge so MOSI holds while the slave samples
                  next_sclk     = 1'b0;
                  next_sp_shift = {sp_shift[6:0], link.spi_miso};
                  if (sp_edges == 5'hF) begin
                     next_sp_cnt   = hup_pkg::SEL_GUARD_CYC;
                     next_sp_state = HUP_SP_HOLD;
                  end
               end
            end else begin
               next_sp_cnt = sp_cnt - 8'h1;
            end
         end
         HUP_SP_HOLD: begin
            if (sp_cnt <= 8'h1) begin
               next_sel_n     = 1'b1;
               next_spi_rdata = sp_shift;
               next_spi_done  = 1'b1;
               next_sp_state  = HUP_SP_IDLE;
            end else begin
               next_sp_cnt = sp_cnt - 8'h1;
            end
         end
         default: next_sp_state = HUP_SP_IDLE;
      endcase
   end

   assign irq_level = irq_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hb_state             <= HUP_HB_IDLE;
         pend_div             <= hup_pkg::INIT_DIV;
         baud_div             <= hup_pkg::INIT_DIV;
         irq_q                <= 1'b0;
         irq_event            <= 1'b0;
         link.host_rts_n      <= 1'b1;
         link.hibernate_req_n <= 1'b1;
         sp_state             <= HUP_SP_IDLE;
         sp_cnt               <= 8'h00;
         sp_edges             <= 5'h00;
         sp_shift             <= 8'h00;
         sclk                 <= 1'b0;
         sel_n                <= 1'b1;
         spi_rdata            <= 8'h00;
         spi_done             <= 1'b0;
      end else begin
         hb_state             <= next_hb_state;
         pend_div             <= next_pend_div;
         baud_div             <= next_baud_div;
         irq_q                <= next_irq_q;
         irq_event            <= next_irq_event;
         link.host_rts_n      <= next_rts_n;
         link.hibernate_req_n <= next_hib_n;
         sp_state             <= next_sp_state;
         sp_cnt               <= next_sp_cnt;
         sp_edges             <= next_sp_edges;
         sp_shift             <= next_sp_shift;
         sclk                 <= next_sclk;
         sel_n                <= next_sel_n;
         spi_rdata            <= next_spi_rdata;
         spi_done             <= next_spi_done;
      end
   end
endmodule

// ---- bench/hup_link_props.sv ----
module hup_link_props (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic dev_to_host,
   input wire logic host_to_dev,
   input wire logic dev_rts_n,
   input wire logic host_irq_out,
   input wire logic spi_sclk,
   input wire logic host_select_n,
   input wire logic spi_miso_oe,
   input wire logic hibernate_req_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_rst;
      $rose(reset_n) |-> dev_to_host && host_to_dev && host_select_n && !spi_sclk;
   endproperty
   a_rst: assert property (p_rst) else $error("idle levels");
   property p_oe_on;
      $fell(host_select_n) && hibernate_req_n |=> spi_miso_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("miso not driven");
   property p_oe_off;
      host_select_n && $past(host_select_n) |-> !spi_miso_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("miso driven");
   property p_sck_hi;
      $rose(spi_sclk) |=> spi_sclk [*4];
   endproperty
   a_sck_hi: assert property (p_sck_hi) else $error("clock high short");
   property p_sck_lo;
      $fell(spi_sclk) |=> !spi_sclk [*4];
   endproperty
   a_sck_lo: assert property (p_sck_lo) else $error("clock low short");
   property p_lead;
      $rose(spi_sclk) |-> !$past(host_select_n) && !$past(host_select_n, 2);
   endproperty
   a_lead: assert property (p_lead) else $error("select lead");
   property p_trail;
      $rose(host_select_n) |-> !$past(spi_sclk) && !$past(spi_sclk, 2);
   endproperty
   a_trail: assert property (p_trail) else $error("select trail");
   property p_start;
      $fell(dev_to_host) |=> !dev_to_host [*8];
   endproperty
   a_start: assert property (p_start) else $error("start bit short");
   property p_hib;
      !hibernate_req_n [*3] |-> !host_irq_out && dev_rts_n;
   endproperty
   a_hib: assert property (p_hib) else $error("awake in hibernate");
endmodule

// ---- bench/host_uart_spi_port_tb.sv ----
module host_uart_spi_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, reset_n, d_txv, h_txv, d_hold, h_hold, d_flow, h_flow, evt, b_req;
   logic        s_go, hib_req, d_txr, h_txr, d_rxv, h_rxv, b_busy, ev, lvl, s_done, d_hib;
   logic        d_srv, s_bsy;
   logic [7:0]  d_txd, h_txd, d_rxd, h_rxd, s_wd, s_rd, d_std, d_srd, d_got, h_got;
   logic [15:0] b_in, db_div, hb_div;
   int          err_count = 0, n_tests = 0, d_n = 0, h_n = 0, s_n = 0;

   hup_link_if link ();
   hup_dev_end u_hup_dev_end (.clk(clk), .reset_n(reset_n), .link(link), .tx_data(d_txd),
      .tx_valid(d_txv), .tx_ready(d_txr), .rx_data(d_rxd), .rx_valid(d_rxv), .rx_hold(d_hold),
      .flow_en(d_flow), .event_req(evt), .spi_tx_data(d_std), .spi_rx_data(d_srd),
      .spi_rx_valid(d_srv), .hibernate(d_hib), .baud_div(db_div));
   hup_host_end u_hup_host_end (.clk(clk), .reset_n(reset_n), .link(link), .tx_data(h_txd),
      .tx_valid(h_txv), .tx_ready(h_txr), .rx_data(h_rxd), .rx_valid(h_rxv), .rx_hold(h_hold),
      .flow_en(h_flow), .baud_req(b_req), .baud_div_in(b_in), .baud_busy(b_busy),
      .baud_div(hb_div), .irq_event(ev), .irq_level(lvl), .spi_start(s_go), .spi_wdata(s_wd),
      .spi_busy(s_bsy), .spi_rdata(s_rd), .spi_done(s_done), .hib_req(hib_req));
   hup_link_props u_hup_link_props (.clk(clk), .reset_n(reset_n),
      .dev_to_host(link.dev_to_host), .host_to_dev(link.host_to_dev),
      .dev_rts_n(link.dev_rts_n), .host_irq_out(link.host_irq_out), .spi_sclk(link.spi_sclk),
      .host_select_n(link.host_select_n), .spi_miso_oe(link.spi_miso_oe),
      .hibernate_req_n(link.hibernate_req_n));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Received UART bytes latched, SPI bytes counted, mid-cycle while their pulse stands
   always @(negedge clk) begin
      if (d_srv === 1'b1) s_n++;
      if (d_rxv === 1'b1) begin
         d_got = d_rxd;
         d_n++;
      end
      if (h_rxv === 1'b1) begin
         h_got = h_rxd;
         h_n++;
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic tmo();
      err_count++;
      wrap_up();
   endtask

   task automatic wait_cnt(ref int c, input int tgt);
      for (int i = 0; i < 40000 && c < tgt; i++) @(negedge clk);
      if (c < tgt) tmo();
   endtask

   task automatic send(input bit dv, input logic [7:0] b);
      int i;
      if (dv) begin
         d_txd = b;
         d_txv = 1'b1;
      end else begin
         h_txd = b;
         h_txv = 1'b1;
      end
      for (i = 0; i < 40000 && (dv ? d_txr : h_txr) !== 1'b1; i++) @(negedge clk);
      if (i == 40000) tmo();
      @(negedge clk);
      if (dv) d_txv = 1'b0;
      else h_txv = 1'b0;
   endtask

   task automatic t_irq();
      int i;
      evt = 1'b1;
      for (i = 0; i < 8 && ev !== 1'b1; i++) @(negedge clk);
      if (i == 8) tmo();
      chk("irq level", 16'(lvl), 16'h0001);
      evt = 1'b0;
      repeat (4) @(negedge clk);
      chk("irq drop", 16'(lvl), 16'h0000);
   endtask

   task automatic t_flow();
      {d_hold, h_hold} = 2'b11;
      repeat (3) @(negedge clk);
      chk("dev ready", 16'(d_txr), 16'h0000);
      chk("host ready", 16'(h_txr), 16'h0000);
      {d_hold, h_hold} = 2'b00;
      repeat (3) @(negedge clk);
      chk("dev ready", 16'(d_txr), 16'h0001);
   endtask

   task automatic t_baud();
      int i;
      send(1'b1, 8'h3C);
      wait_cnt(h_n, 1);
      chk("host rx", 16'(h_got), 16'h003C);
      b_in = 16'h0010;
      b_req = 1'b1;
      @(negedge clk);
      b_req = 1'b0;
      for (i = 0; i < 60000 && b_busy !== 1'b0; i++) @(negedge clk);
      if (i == 60000) tmo();
      chk("host div", hb_div, hup_pkg::MIN_DIV);
      chk("dev div", db_div, hup_pkg::MIN_DIV);
   endtask

   task automatic t_fast();
      int dn, hn;
      dn = d_n;
      hn = h_n;
      // Three-wire style: host line held high, device must ignore it
      {h_hold, d_flow} = 2'b10;
      fork
         send(1'b0, 8'hA5);
         send(1'b1, 8'h5A);
      join
      wait_cnt(d_n, dn + 1);
      wait_cnt(h_n, hn + 1);
      chk("dev rx", 16'(d_got), 16'h00A5);
      chk("host rx", 16'(h_got), 16'h005A);
      {h_hold, d_flow} = 2'b01;
   endtask

   task automatic t_spi(input logic [7:0] hw, input logic [7:0] dw);
      int i, sn;
      sn = s_n;
      s_wd = hw;
      d_std = dw;
      s_go = 1'b1;
      @(negedge clk);
      s_go = 1'b0;
      for (i = 0; i < 200 && s_done !== 1'b1; i++) @(negedge clk);
      if (i == 200) tmo();
      chk("host spi", 16'(s_rd), 16'(dw));
      chk("dev spi", 16'(d_srd), 16'(hw));
      chk("dev spi count", 16'(s_n - sn), 16'h0001);
      chk("spi busy", 16'(s_bsy), 16'h0000);
   endtask

   task automatic t_hib();
      hib_req = 1'b1;
      evt = 1'b1;
      repeat (4) @(negedge clk);
      chk("hibernate", 16'(d_hib), 16'h0001);
      chk("irq", 16'(link.host_irq_out), 16'h0000);
      {hib_req, evt} = 2'b00;
      repeat (4) @(negedge clk);
      chk("wake", 16'(d_hib), 16'h0000);
   endtask

   initial begin
      {reset_n, d_txv, h_txv, d_hold, h_hold, evt, b_req, s_go, hib_req} = '0;
      {d_flow, h_flow} = 2'b11;
      {d_txd, h_txd, s_wd, d_std, b_in} = '0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      chk("dev div", db_div, hup_pkg::INIT_DIV);
      t_irq();
      t_flow();
      t_baud();
      t_fast();
      t_spi(8'h96, 8'h5A);
      t_spi(8'h3C, 8'hC3);
      t_hib();
      wrap_up();
   end
endmodule
